// *** src/mpc_pkg.sv ***
package mpc_pkg;
	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
	localparam int unsigned EVENT_MIN_MS = 50;
	localparam int unsigned OVERRIDE_S = 4;
	localparam int unsigned RESET_WAIT_MAX_MS = 25;
	localparam int unsigned RESET_HOLD_MIN_MS = 5;
	localparam int unsigned RESET_HOLD_MAX_MS = 6;
	// least and longest times both round down through CLK_PER_MS; all are exact at 50 MHz
	localparam int unsigned EVENT_MIN_CYC = CLK_PER_MS * EVENT_MIN_MS;
	localparam int unsigned OVERRIDE_CYC = CLK_HZ * OVERRIDE_S;
	localparam int unsigned RESET_WAIT_CYC = CLK_PER_MS * RESET_WAIT_MAX_MS;
	localparam int unsigned RESET_HOLD_CYC = CLK_PER_MS * RESET_HOLD_MIN_MS;
	localparam int unsigned RESET_HOLD_LIMIT_CYC = CLK_PER_MS * RESET_HOLD_MAX_MS;
	localparam int unsigned CNT_W = 28;

	// ----------------------------------------------------------------
	// start-up settle and synchroniser lanes
	// ----------------------------------------------------------------
	localparam logic [1:0] BOOT_SETTLE = 2'h3;
	localparam int unsigned IN_POWER_BUTTON_N = 0;
	localparam int unsigned IN_SUPPLY = 1;
	localparam int unsigned IN_RSTBTN = 2;
	localparam int unsigned IN_ALERT = 3;
	localparam int unsigned IN_BATTERY_LOW_N = 4;
	localparam int unsigned IN_PCIE_WAKE = 5;
	localparam int unsigned IN_GP_WAKE = 6;
	localparam int unsigned IN_SMB_IDLE = 7;
	localparam int unsigned IN_MAIN = 8;
	localparam int unsigned IN_STAY_OFF = 9;
	localparam int unsigned IN_W = 10;
	localparam logic [IN_W-1:0] IN_RESET_VAL = 10'h07d;

	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		PWR_OFF = 3'h0,
		PWR_RAM = 3'h1,
		PWR_DISK = 3'h2,
		PWR_UP = 3'h3,
		PWR_ON = 3'h4
	} mpc_pwr_e;

	typedef enum logic [1:0] {
		RST_IDLE = 2'h0,
		RST_WAIT = 2'h1,
		RST_HOLD = 2'h2
	} mpc_rst_e;
endpackage

// *** src/mpc_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module mpc_sync #(
	parameter int unsigned W = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	if (W < 1) begin : g_bad_w
		$error("mpc_sync: W must be at least 1");
	end

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} mpc_sync_s;

	mpc_sync_s s_q;
	mpc_sync_s s_d;

	// first stage feeds only the second stage
	always_comb begin
		s_d.meta = async_in;
		s_d.stable = s_q.meta;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			s_q <= {RESET_VAL, RESET_VAL};
		end else begin
			s_q <= s_d;
		end
	end

	assign sync_out = s_q.stable;
endmodule // mpc_sync
`default_nettype wire

// *** src/mpc_press_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
module mpc_press_timer #(
	parameter int unsigned CNT_W = 28,
	parameter int unsigned MIN_CYC = 2_500_000,
	parameter int unsigned OVR_CYC = 200_000_000
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic level_n,
	output logic press_event,
	output logic press_override
);
	if (MIN_CYC < 1 || OVR_CYC <= MIN_CYC || OVR_CYC > (2 ** CNT_W)) begin : g_bad
		$error("mpc_press_timer: counts do not fit");
	end

	localparam logic [CNT_W-1:0] MIN_M1 = CNT_W'(MIN_CYC - 1);
	localparam logic [CNT_W-1:0] OVR_M1 = CNT_W'(OVR_CYC - 1);

	typedef struct packed {
		logic prev_n;
		logic armed;
		logic [CNT_W-1:0] cnt;
		logic ev;
		logic ovr;
	} mpc_press_s;

	mpc_press_s s_q;
	mpc_press_s s_d;

	// ----------------------------------------------------------------
	// low-time measurement
	// ----------------------------------------------------------------
	// a press is only timed from a falling edge; prev_n and the synchroniser reset high,
	// so a button stuck low at start-up is timed as a press from just after reset
	always_comb begin
		s_d = s_q;
		s_d.prev_n = level_n;
		s_d.ev = 1'b0;
		s_d.ovr = 1'b0;
		if (s_q.prev_n && !level_n) begin
			s_d.armed = 1'b1;
			s_d.cnt = '0;
		end else if (s_q.armed && !level_n) begin
			if (s_q.cnt == OVR_M1) begin
				s_d.ovr = 1'b1;
				s_d.armed = 1'b0;
			end else begin
				s_d.cnt = s_q.cnt + 1'b1;
			end
		end else if (s_q.armed) begin
			s_d.armed = 1'b0;
			s_d.ev = (s_q.cnt >= MIN_M1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			s_q <= '{prev_n: 1'b1, armed: 1'b0, cnt: '0, ev: 1'b0, ovr: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign press_event = s_q.ev;
	assign press_override = s_q.ovr;
endmodule // mpc_press_timer
`default_nettype wire

// *** src/mpc_power_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
module mpc_power_ctrl #(
	parameter int unsigned EVENT_MIN_CYC = mpc_pkg::EVENT_MIN_CYC,
	parameter int unsigned OVERRIDE_CYC = mpc_pkg::OVERRIDE_CYC,
	parameter int unsigned RESET_WAIT_CYC = mpc_pkg::RESET_WAIT_CYC,
	parameter int unsigned RESET_HOLD_CYC = mpc_pkg::RESET_HOLD_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic power_button_n,
	input wire logic supply_good_in,
	input wire logic reset_button_n,
	input wire logic smbus_alert_n,
	input wire logic battery_low_n,
	input wire logic pcie_wake_n,
	input wire logic general_wake_n,
	input wire logic smbus_idle,
	input wire logic main_supply_present,
	input wire logic stay_off_policy,
	input wire logic sleep_ram_req,
	input wire logic sleep_disk_req,
	input wire logic soft_off_req,
	output logic supply_enable,
	output logic system_reset_n,
	output logic carrier_reset_request_n,
	output logic smi_request,
	output logic suspend_ram_n,
	output logic suspend_disk_n,
	output logic soft_off_n
);
	localparam int unsigned CW = mpc_pkg::CNT_W;

	if (RESET_WAIT_CYC < 1 || RESET_HOLD_CYC < 1 ||
		RESET_WAIT_CYC > (2 ** CW) || RESET_HOLD_CYC > (2 ** CW)) begin : g_bad_rst
		$error("mpc_power_ctrl: reset counts do not fit the counter");
	end
	if (RESET_HOLD_CYC > mpc_pkg::RESET_HOLD_LIMIT_CYC) begin : g_bad_hold
		$error("mpc_power_ctrl: reset hold longer than allowed");
	end

	localparam logic [CW-1:0] WAIT_M1 = CW'(RESET_WAIT_CYC - 1);
	localparam logic [CW-1:0] HOLD_M1 = CW'(RESET_HOLD_CYC - 1);

	// ----------------------------------------------------------------
	// state pin decode
	// ----------------------------------------------------------------
	// one pin each for the off, RAM, disk and on states (on active high, power-up has none); shared so the pins cannot disagree
	function automatic logic state_pin_n(
		input mpc_pkg::mpc_pwr_e cur,
		input mpc_pkg::mpc_pwr_e shown
	);
		return cur != shown;
	endfunction

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [mpc_pkg::IN_W-1:0] raw_in;
	logic [mpc_pkg::IN_W-1:0] syn;

	always_comb begin
		raw_in = '0;
		raw_in[mpc_pkg::IN_POWER_BUTTON_N] = power_button_n;
		raw_in[mpc_pkg::IN_SUPPLY] = supply_good_in;
		raw_in[mpc_pkg::IN_RSTBTN] = reset_button_n;
		raw_in[mpc_pkg::IN_ALERT] = smbus_alert_n;
		raw_in[mpc_pkg::IN_BATTERY_LOW_N] = battery_low_n;
		raw_in[mpc_pkg::IN_PCIE_WAKE] = pcie_wake_n;
		raw_in[mpc_pkg::IN_GP_WAKE] = general_wake_n;
		raw_in[mpc_pkg::IN_SMB_IDLE] = smbus_idle;
		raw_in[mpc_pkg::IN_MAIN] = main_supply_present;
		raw_in[mpc_pkg::IN_STAY_OFF] = stay_off_policy;
	end

	mpc_sync #(
		.W(mpc_pkg::IN_W),
		.RESET_VAL(mpc_pkg::IN_RESET_VAL)
	) u_sync (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.async_in(raw_in),
		.sync_out(syn)
	);

	// ----------------------------------------------------------------
	// power button timing
	// ----------------------------------------------------------------
	logic btn_event;
	logic btn_override;

	mpc_press_timer #(
		.CNT_W(CW),
		.MIN_CYC(EVENT_MIN_CYC),
		.OVR_CYC(OVERRIDE_CYC)
	) u_press (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.level_n(syn[mpc_pkg::IN_POWER_BUTTON_N]),
		.press_event(btn_event),
		.press_override(btn_override)
	);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		mpc_pkg::mpc_pwr_e pwr;
		mpc_pkg::mpc_rst_e rst;
		logic [CW-1:0] rcnt;
		logic [1:0] boot;
		logic rstbtn_prev_n;
		logic alert_prev_n;
		logic supply_en;
		logic sys_rst_n;
		logic cb_rst_n;
		logic smi;
		logic ram_n;
		logic disk_n;
		logic off_n;
	} mpc_ctrl_s;

	mpc_ctrl_s s_q;
	mpc_ctrl_s s_d;

	logic supply_ok;
	logic main_ok;
	logic alert_low;
	logic alert_fall;
	logic batt_low;
	logic wake_any;
	logic rstbtn_fall;

	always_comb begin
		supply_ok = syn[mpc_pkg::IN_SUPPLY];
		main_ok = syn[mpc_pkg::IN_MAIN];
		alert_low = !syn[mpc_pkg::IN_ALERT];
		alert_fall = s_q.alert_prev_n && alert_low;
		batt_low = !syn[mpc_pkg::IN_BATTERY_LOW_N];
		wake_any = !syn[mpc_pkg::IN_PCIE_WAKE] || !syn[mpc_pkg::IN_GP_WAKE] || alert_low;
		rstbtn_fall = s_q.rstbtn_prev_n && !syn[mpc_pkg::IN_RSTBTN];
	end

	always_comb begin
		s_d = s_q;
		s_d.rstbtn_prev_n = syn[mpc_pkg::IN_RSTBTN];
		s_d.alert_prev_n = !alert_low;
		s_d.smi = 1'b0;

		// ------------------------------------------------------------
		// power state machine
		// ------------------------------------------------------------
		case (s_q.pwr)
			mpc_pkg::PWR_OFF: begin
				if (s_q.boot != mpc_pkg::BOOT_SETTLE) begin
					s_d.boot = s_q.boot + 2'h1;
				end
				// policy is read once the synchronisers have settled
				if (btn_event || alert_low) begin
					s_d.pwr = mpc_pkg::PWR_UP;
				end else if (s_q.boot == mpc_pkg::BOOT_SETTLE - 2'h1 &&
					!syn[mpc_pkg::IN_STAY_OFF]) begin
					s_d.pwr = mpc_pkg::PWR_UP;
				end
			end
			mpc_pkg::PWR_RAM: begin
				if (batt_low) begin
					s_d.pwr = mpc_pkg::PWR_DISK;
				end else if (btn_event || wake_any) begin
					s_d.pwr = mpc_pkg::PWR_UP;
				end
			end
			mpc_pkg::PWR_DISK: begin
				if (btn_event || wake_any) begin
					s_d.pwr = mpc_pkg::PWR_UP;
				end
			end
			mpc_pkg::PWR_UP: begin
				// stay here, supplies off, until carrier and main rail allow
				if (supply_ok && main_ok) begin
					s_d.pwr = mpc_pkg::PWR_ON;
				end
			end
			mpc_pkg::PWR_ON: begin
				// losing supply good while running is a power failure
				if (!supply_ok) begin
					s_d.pwr = mpc_pkg::PWR_OFF;
				end else if (btn_event || soft_off_req) begin
					s_d.pwr = mpc_pkg::PWR_OFF;
				end else if (batt_low || sleep_disk_req) begin
					s_d.pwr = mpc_pkg::PWR_DISK;
				end else if (sleep_ram_req) begin
					s_d.pwr = mpc_pkg::PWR_RAM;
				end
				s_d.smi = alert_fall;
			end
			default: begin
				s_d.pwr = mpc_pkg::PWR_OFF;
			end
		endcase
		if (btn_override) begin
			s_d.pwr = mpc_pkg::PWR_OFF;
		end
		// an alert edge in the cycle that leaves the on state is dropped:
		// no SMI is raised while the supplies go down
		if (s_d.pwr != mpc_pkg::PWR_ON) begin
			s_d.smi = 1'b0;
		end

		// ------------------------------------------------------------
		// graceful reset sequence
		// ------------------------------------------------------------
		case (s_q.rst)
			mpc_pkg::RST_IDLE: begin
				if (rstbtn_fall) begin
					s_d.rst = mpc_pkg::RST_WAIT;
					s_d.rcnt = '0;
				end
			end
			mpc_pkg::RST_WAIT: begin
				// force the reset once the wait limit runs out
				if (syn[mpc_pkg::IN_SMB_IDLE] || s_q.rcnt == WAIT_M1) begin
					s_d.rst = mpc_pkg::RST_HOLD;
					s_d.rcnt = '0;
				end else begin
					s_d.rcnt = s_q.rcnt + 1'b1;
				end
			end
			mpc_pkg::RST_HOLD: begin
				// button level is ignored; a new falling edge is dropped here
				if (s_q.rcnt == HOLD_M1) begin
					s_d.rst = mpc_pkg::RST_IDLE;
					s_d.rcnt = '0;
				end else begin
					s_d.rcnt = s_q.rcnt + 1'b1;
				end
			end
			default: begin
				s_d.rst = mpc_pkg::RST_IDLE;
				s_d.rcnt = '0;
			end
		endcase

		// ------------------------------------------------------------
		// registered outputs
		// ------------------------------------------------------------
		s_d.supply_en = !state_pin_n(s_d.pwr, mpc_pkg::PWR_ON);
		s_d.sys_rst_n = (s_d.rst != mpc_pkg::RST_HOLD);
		s_d.cb_rst_n = (s_d.rst != mpc_pkg::RST_HOLD);
		s_d.ram_n = state_pin_n(s_d.pwr, mpc_pkg::PWR_RAM);
		s_d.disk_n = state_pin_n(s_d.pwr, mpc_pkg::PWR_DISK);
		s_d.off_n = state_pin_n(s_d.pwr, mpc_pkg::PWR_OFF);
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			s_q <= '{
				pwr: mpc_pkg::PWR_OFF,
				rst: mpc_pkg::RST_IDLE,
				rcnt: '0,
				boot: 2'h0,
				rstbtn_prev_n: 1'b1,
				alert_prev_n: 1'b1,
				supply_en: 1'b0,
				sys_rst_n: 1'b1,
				cb_rst_n: 1'b1,
				smi: 1'b0,
				ram_n: 1'b1,
				disk_n: 1'b1,
				off_n: 1'b0
			};
		end else begin
			s_q <= s_d;
		end
	end

	assign supply_enable = s_q.supply_en;
	assign system_reset_n = s_q.sys_rst_n;
	assign carrier_reset_request_n = s_q.cb_rst_n;
	assign smi_request = s_q.smi;
	assign suspend_ram_n = s_q.ram_n;
	assign suspend_disk_n = s_q.disk_n;
	assign soft_off_n = s_q.off_n;
endmodule // mpc_power_ctrl
`default_nettype wire

// *** verif/mpc_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
module mpc_checker #(
	parameter int unsigned RESET_WAIT_CYC = 16,
	parameter int unsigned RESET_HOLD_CYC = 10,
	parameter int unsigned OVERRIDE_CYC = 40
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic power_button_n,
	input wire logic supply_good_in,
	input wire logic reset_button_n,
	input wire logic main_supply_present,
	input wire logic supply_enable,
	input wire logic system_reset_n,
	input wire logic carrier_reset_request_n,
	input wire logic smi_request,
	input wire logic suspend_ram_n,
	input wire logic suspend_disk_n,
	input wire logic soft_off_n
);
	// sync, timer and state stages add a few cycles
	localparam int WAIT_LIM = RESET_WAIT_CYC + 6;
	localparam int OVR_LIM = OVERRIDE_CYC + 7;
	logic [27:0] hold_q;
	logic [27:0] btn_q;
	always_ff @(posedge sys_clk) begin
		hold_q <= (!rst_b || system_reset_n) ? 28'h0 : hold_q + 28'h1;
		if (!rst_b || power_button_n) btn_q <= 28'h0;
		else if (btn_q != OVR_LIM) btn_q <= btn_q + 28'h1;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	a_reset_pins_same: assert property (system_reset_n == carrier_reset_request_n)
		else $error("reset outputs differ");
	a_reset_hold_len: assert property ($rose(system_reset_n) |-> hold_q == RESET_HOLD_CYC)
		else $error("reset hold length wrong");
	a_reset_wait_max: assert property (
		$fell(reset_button_n) && system_reset_n |-> ##[1:WAIT_LIM] !system_reset_n)
		else $error("reset not forced in time");
	a_supply_gate: assert property (
		$rose(supply_enable) |-> $past(supply_good_in, 3) && $past(main_supply_present, 3))
		else $error("power up without supply good");
	a_power_fail_off: assert property (
		supply_enable && !supply_good_in |-> ##[1:5] !supply_enable)
		else $error("no power down on supply loss");
	a_one_state_out: assert property (
		$onehot0({!suspend_ram_n, !suspend_disk_n, !soft_off_n, supply_enable}))
		else $error("state outputs overlap");
	a_smi_one_pulse: assert property (smi_request |-> supply_enable ##1 !smi_request)
		else $error("smi pulse wrong");
	a_override_off: assert property (btn_q == OVR_LIM |-> !supply_enable && !soft_off_n)
		else $error("override did not power off");
	c_ram: cover property ($fell(suspend_ram_n));
	c_reset: cover property ($fell(system_reset_n));
	c_smi: cover property (smi_request);
	c_override: cover property (btn_q == OVR_LIM);
endmodule // mpc_checker
bind mpc_power_ctrl mpc_checker #(
	.RESET_WAIT_CYC(RESET_WAIT_CYC),
	.RESET_HOLD_CYC(RESET_HOLD_CYC),
	.OVERRIDE_CYC(OVERRIDE_CYC)
) u_chk (
	.sys_clk(sys_clk),
	.rst_b(rst_b),
	.power_button_n(power_button_n),
	.supply_good_in(supply_good_in),
	.reset_button_n(reset_button_n),
	.main_supply_present(main_supply_present),
	.supply_enable(supply_enable),
	.system_reset_n(system_reset_n),
	.carrier_reset_request_n(carrier_reset_request_n),
	.smi_request(smi_request),
	.suspend_ram_n(suspend_ram_n),
	.suspend_disk_n(suspend_disk_n),
	.soft_off_n(soft_off_n)
);
`default_nettype wire

// *** verif/mpc_carrier.sv ***
`timescale 1ns/10ps
`default_nettype none
module mpc_carrier (
	input wire logic sys_clk,
	input wire logic rail_on,
	input wire logic fail,
	input wire logic slow,
	output logic main_supply_present,
	output logic supply_good_in
);
	logic [3:0] ramp_q;
	always_ff @(posedge sys_clk) begin
		if (!rail_on || fail) ramp_q <= 4'h0;
		else if (ramp_q != 4'hf) ramp_q <= ramp_q + 4'h1;
	end
	// good trails the rail; only a fail drops it while running
	// slow rail: main lags supply good, so the main-supply gate is exercised
	assign main_supply_present = ramp_q > (slow ? 4'hb : 4'h1);
	assign supply_good_in = ramp_q > (slow ? 4'h5 : 4'h3);
endmodule // mpc_carrier
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic sys_clk = 0, rst_b = 0, power_button_n = 1, reset_button_n = 1;
	logic smbus_alert_n = 1, battery_low_n = 1, pcie_wake_n = 1, general_wake_n = 1;
	logic smbus_idle = 1, stay_off_policy = 1, sleep_ram_req = 0, sleep_disk_req = 0;
	logic soft_off_req = 0, fail = 0, slow = 0;
	logic supply_good_in, main_supply_present, supply_enable, system_reset_n;
	logic carrier_reset_request_n, smi_request, suspend_ram_n, suspend_disk_n, soft_off_n;
	int miscompares = 0, tests_run = 0, cyc = 0;
	mpc_power_ctrl #(.EVENT_MIN_CYC(8), .OVERRIDE_CYC(40), .RESET_WAIT_CYC(16),
		.RESET_HOLD_CYC(10)) DUT (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.power_button_n(power_button_n),
		.supply_good_in(supply_good_in),
		.reset_button_n(reset_button_n),
		.smbus_alert_n(smbus_alert_n),
		.battery_low_n(battery_low_n),
		.pcie_wake_n(pcie_wake_n),
		.general_wake_n(general_wake_n),
		.smbus_idle(smbus_idle),
		.main_supply_present(main_supply_present),
		.stay_off_policy(stay_off_policy),
		.sleep_ram_req(sleep_ram_req),
		.sleep_disk_req(sleep_disk_req),
		.soft_off_req(soft_off_req),
		.supply_enable(supply_enable),
		.system_reset_n(system_reset_n),
		.carrier_reset_request_n(carrier_reset_request_n),
		.smi_request(smi_request),
		.suspend_ram_n(suspend_ram_n),
		.suspend_disk_n(suspend_disk_n),
		.soft_off_n(soft_off_n)
	);
	mpc_carrier u_car (.sys_clk(sys_clk), .rail_on(suspend_ram_n & suspend_disk_n & soft_off_n),
		.fail(fail), .slow(slow), .main_supply_present(main_supply_present),
		.supply_good_in(supply_good_in));
	initial forever #10 sys_clk = ~sys_clk;
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wait_on(input logic v);
		for (int i = 0; i < 60 && supply_enable !== v; i++) tick(1);
	endtask
	task automatic press(input int n);
		power_button_n = 0;
		tick(n);
		power_button_n = 1;
		tick(1);
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		tick(1);
		s = 0;
		tick(3);
	endtask
	task automatic until_rst(output int n);
		n = 0;
		while (system_reset_n !== 1'b0 && n < 40) begin
			tick(1);
			n++;
		end
	endtask
	task automatic hold_len(output int k, output logic same);
		k = 0;
		same = 1;
		while (system_reset_n === 1'b0 && k < 30) begin
			if (carrier_reset_request_n !== 1'b0) same = 0;
			tick(1);
			k++;
		end
	endtask
	task automatic t_short();
		press(7);
		tick(10);
		chk(8'(soft_off_n), 8'h0);
	endtask
	task automatic t_wake();
		press(8);
		wait_on(1'b1);
		chk(8'({soft_off_n, supply_enable}), 8'h3);
	endtask
	task automatic t_smi();
		int n = 0;
		smbus_alert_n = 0;
		repeat (8) begin
			tick(1);
			if (smi_request === 1'b1) n++;
		end
		smbus_alert_n = 1;
		// let the synchronised alert rise, or the next suspend wakes at once
		tick(4);
		chk(8'(n), 8'h1);
	endtask
	task automatic t_ram();
		pulse(sleep_ram_req);
		chk(8'({suspend_ram_n, supply_enable}), 8'h0);
		pcie_wake_n = 0;
		wait_on(1'b1);
		pcie_wake_n = 1;
		chk(8'(supply_enable), 8'h1);
		tick(4);
	endtask
	task automatic t_disk();
		pulse(sleep_disk_req);
		chk(8'({suspend_disk_n, supply_enable}), 8'h0);
		general_wake_n = 0;
		wait_on(1'b1);
		general_wake_n = 1;
		chk(8'(supply_enable), 8'h1);
		tick(4);
	endtask
	task automatic t_battery_low_n();
		battery_low_n = 0;
		tick(6);
		chk(8'(suspend_disk_n), 8'h0);
		battery_low_n = 1;
		press(8);
		wait_on(1'b1);
		chk(8'(supply_enable), 8'h1);
	endtask
	task automatic t_reset();
		int n;
		int k;
		logic same;
		smbus_idle = 0;
		reset_button_n = 0;
		until_rst(n);
		reset_button_n = 1;
		chk(8'(n >= 16 && n <= 24), 8'h1);
		hold_len(k, same);
		chk(8'(k), 8'h0a);
		chk(8'(same), 8'h1);
		smbus_idle = 1;
		reset_button_n = 0;
		until_rst(n);
		chk(8'(n <= 6), 8'h1);
		hold_len(k, same);
		reset_button_n = 1;
		chk(8'(k), 8'h0a);
	endtask
	task automatic t_pwr_down();
		press(8);
		wait_on(1'b0);
		chk(8'(soft_off_n), 8'h0);
	endtask
	task automatic t_alert();
		smbus_alert_n = 0;
		wait_on(1'b1);
		smbus_alert_n = 1;
		chk(8'(supply_enable), 8'h1);
	endtask
	task automatic t_fail();
		fail = 1;
		wait_on(1'b0);
		chk(8'(soft_off_n), 8'h0);
		press(8);
		tick(30);
		chk(8'({soft_off_n, supply_enable}), 8'h2);
		fail = 0;
		slow = 1;
		// supply good is up by now, the main rail is not
		tick(10);
		chk(8'(supply_enable), 8'h0);
		wait_on(1'b1);
		chk(8'(supply_enable), 8'h1);
		pulse(soft_off_req);
		chk(8'(soft_off_n), 8'h0);
		press(8);
		wait_on(1'b1);
	endtask
	task automatic t_override();
		power_button_n = 0;
		tick(48);
		chk(8'({soft_off_n, supply_enable}), 8'h0);
		power_button_n = 1;
		tick(10);
		chk(8'(soft_off_n), 8'h0);
	endtask
	task automatic t_policy();
		// second reset with the policy set to power on by itself
		stay_off_policy = 0;
		rst_b = 0;
		tick(3);
		rst_b = 1;
		tick(1);
		chk(8'({supply_enable, soft_off_n}), 8'h0);
		wait_on(1'b1);
		chk(8'(supply_enable), 8'h1);
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		tick(12);
		chk(8'({supply_enable, system_reset_n, carrier_reset_request_n, smi_request,
			suspend_ram_n, suspend_disk_n, soft_off_n}), 8'h36);
		rst_b = 1;
		tick(6);
		t_short();
		t_wake();
		t_smi();
		t_ram();
		t_disk();
		t_battery_low_n();
		t_reset();
		t_pwr_down();
		t_alert();
		t_fail();
		t_override();
		t_policy();
		complete_run();
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 4000) begin
			miscompares++;
			complete_run();
		end
	end
endmodule // testbench
`default_nettype wire
